//--- rtl/fcms_pkg.sv
`default_nettype none
package fcms_pkg;
  // mode pin codes
  localparam logic [2:0] MODE_PROM = 3'h0;
  localparam logic [2:0] MODE_SPI = 3'h6;
  localparam logic [2:0] MODE_PAR_UP = 3'h2;
  localparam logic [2:0] MODE_PAR_DOWN = 3'h3;
  // flash addressing
  localparam logic [24:0] PAR_BOTTOM_ADDR = 25'h0000000;
  localparam logic [24:0] PAR_TOP_ADDR = 25'h1ffffff;
  localparam int PAR_LOW_BITS = 20;
  localparam logic [31:0] SPI_READ_CMD = 32'h03000000;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int PAR_ACCESS_NS = 120;
  localparam logic [3:0] PAR_ACCESS_CYC =
    4'((PAR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int CONFIG_CLOCK_HALF_CYC = 2;
  localparam logic [2:0] SETTLE_CYC = 3'h4;
  localparam logic [24:0] IMAGE_BYTES_RST = 25'h0000100;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IMAGE_LEN = 8'h08;
  localparam logic [7:0] REG_ADDR = 8'h0c;
  localparam logic [7:0] REG_BYTE_CNT = 8'h10;
  localparam logic [7:0] REG_INT_STATUS = 8'h14;
  localparam logic [7:0] REG_INT_MASK = 8'h18;
  // field positions
  localparam int CTRL_RECONFIG_BIT = 0;
  localparam int STAT_STATE_POS = 0;
  localparam int STAT_SRC_POS = 4;
  localparam int STAT_MODE_POS = 8;
  localparam int STAT_LIVE_POS = 12;
  localparam int STAT_DONE_BIT = 16;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_FAIL_BIT = 1;
  localparam int INT_UNSUP_BIT = 2;
  localparam int INT_WIDTH = 3;
  localparam logic [2:0] INT_MASK_RST = 3'h0;

  typedef enum logic [2:0] {
    ST_POWER = 3'b000,
    ST_SAMPLE = 3'b001,
    ST_CMD = 3'b010,
    ST_LOAD = 3'b011,
    ST_JTAG = 3'b100,
    ST_DONE = 3'b101,
    ST_FAIL = 3'b110,
    ST_UNSUP = 3'b111
  } fcms_state_t;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_PROM = 3'b001,
    SRC_SPI = 3'b010,
    SRC_PAR_UP = 3'b011,
    SRC_PAR_DOWN = 3'b100
  } fcms_src_t;

  typedef struct packed {
    logic configClock;
    logic promSel_n;
    logic spiSel_n;
    logic spiMosi;
    logic parSel_n;
    logic [19:0] parAddr;
  } fcms_flash_t;
endpackage
`default_nettype wire

//--- rtl/fcms_sync.sv
`default_nettype none
module fcms_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // pins in, filtered level out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          stage1[i] <= RESET_VAL[i];
          stage2[i] <= RESET_VAL[i];
          stage3[i] <= RESET_VAL[i];
          dout[i] <= RESET_VAL[i];
        end else begin
          stage1[i] <= din[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          // a change counts once two stages agree
          if (stage2[i] == stage3[i]) begin
            dout[i] <= stage3[i];
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- rtl/fcms_loader.sv
// Decided for this implementation: the APB slave port and the register offsets.
`default_nettype none
module fcms_loader #(
  parameter int CONFIG_CLOCK_HALF = fcms_pkg::CONFIG_CLOCK_HALF_CYC,
  parameter logic [24:0] IMAGE_BYTES = fcms_pkg::IMAGE_BYTES_RST
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // board pins
  input wire logic [2:0] modeSelectPins,
  input wire logic reconfigRequest_n,
  // configuration memories
  input wire logic serialIn,
  input wire logic [7:0] parData,
  output fcms_pkg::fcms_flash_t flashBus,
  // jtag download stream
  input wire logic jtagStart,
  input wire logic jtagValid,
  input wire logic [7:0] jtagByte,
  input wire logic jtagLast,
  // status
  output logic configDone,
  output logic irq
);
  fcms_pkg::fcms_state_t state;
  fcms_pkg::fcms_src_t src;
  logic [3:0] syncIn;
  logic [2:0] livePins;
  logic progPressed;
  logic softReq;
  logic restart;
  logic [2:0] settleCnt;
  logic settleDone;
  logic [2:0] modeLatched;
  logic [24:0] addr;
  logic [24:0] byteCnt;
  logic [24:0] imageLen;
  logic [7:0] xorAcc;
  logic [7:0] shiftIn;
  logic [31:0] shiftOut;
  logic [4:0] bitCnt;
  logic [7:0] divCnt;
  logic tick;
  logic cclkRise;
  logic serialActive;
  logic isPar;
  logic [3:0] accCnt;
  logic gotByte;
  logic [7:0] newByte;
  logic lastByte;
  logic finish;
  logic imageOk;
  logic [2:0] intStatus;
  logic [2:0] intMask;
  logic [2:0] intEvent;
  logic access;
  logic wrEn;
  logic mapped;
  logic [31:0] rdData;

  // mode pin code to configuration source
  function automatic fcms_pkg::fcms_src_t modeKind(input logic [2:0] code);
    case (code)
      fcms_pkg::MODE_PROM: modeKind = fcms_pkg::SRC_PROM;
      fcms_pkg::MODE_SPI: modeKind = fcms_pkg::SRC_SPI;
      fcms_pkg::MODE_PAR_UP: modeKind = fcms_pkg::SRC_PAR_UP;
      fcms_pkg::MODE_PAR_DOWN: modeKind = fcms_pkg::SRC_PAR_DOWN;
      default: modeKind = fcms_pkg::SRC_NONE;
    endcase
  endfunction

  fcms_sync #(
    .WIDTH(4),
    .RESET_VAL(4'hf)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .din({reconfigRequest_n, modeSelectPins}),
    .dout(syncIn)
  );

  assign livePins = syncIn[2:0];
  assign progPressed = ~syncIn[3];
  assign restart = progPressed | softReq;
  assign settleDone = (settleCnt == fcms_pkg::SETTLE_CYC);
  assign isPar = (src == fcms_pkg::SRC_PAR_UP) | (src == fcms_pkg::SRC_PAR_DOWN);
  assign serialActive = ((state == fcms_pkg::ST_CMD) | (state == fcms_pkg::ST_LOAD)) & ~isPar;
  assign tick = serialActive & (divCnt == 8'(CONFIG_CLOCK_HALF - 1));
  assign cclkRise = tick & ~flashBus.configClock;

  always_comb begin
    gotByte = 1'b0;
    newByte = 8'h00;
    lastByte = 1'b0;
    if (state == fcms_pkg::ST_JTAG) begin
      gotByte = jtagValid;
      newByte = jtagByte;
      lastByte = jtagValid & jtagLast;
    end else if (state == fcms_pkg::ST_LOAD) begin
      if (isPar) begin
        gotByte = (accCnt == fcms_pkg::PAR_ACCESS_CYC);
        newByte = parData;
      end else begin
        gotByte = cclkRise & (bitCnt[2:0] == 3'h7);
        newByte = {shiftIn[6:0], serialIn};
      end
      lastByte = gotByte & (byteCnt == imageLen - 25'h0000001);
    end
  end

  assign finish = lastByte & ~restart;
  assign imageOk = ((xorAcc ^ newByte) == 8'h00);

  // settle counter after power-up or restart
  always_ff @(posedge clk_sys) begin
    if (reset || restart || state != fcms_pkg::ST_SAMPLE) begin
      settleCnt <= 3'h0;
    end else if (!settleDone) begin
      settleCnt <= settleCnt + 3'h1;
    end
  end

  // main sequence
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= fcms_pkg::ST_POWER;
    end else if (restart) begin
      state <= fcms_pkg::ST_SAMPLE;
    end else begin
      case (state)
        fcms_pkg::ST_POWER: begin
          state <= fcms_pkg::ST_SAMPLE;
        end
        fcms_pkg::ST_SAMPLE: begin
          if (settleDone) begin
            case (modeKind(livePins))
              fcms_pkg::SRC_SPI: state <= fcms_pkg::ST_CMD;
              fcms_pkg::SRC_NONE: state <= fcms_pkg::ST_UNSUP;
              default: state <= fcms_pkg::ST_LOAD;
            endcase
          end
        end
        fcms_pkg::ST_CMD: begin
          if (cclkRise && bitCnt == 5'h1f) begin
            state <= fcms_pkg::ST_LOAD;
          end
        end
        fcms_pkg::ST_LOAD, fcms_pkg::ST_JTAG: begin
          if (finish) begin
            state <= imageOk ? fcms_pkg::ST_DONE : fcms_pkg::ST_FAIL;
          end
        end
        fcms_pkg::ST_DONE, fcms_pkg::ST_FAIL, fcms_pkg::ST_UNSUP: begin
          if (jtagStart) begin
            state <= fcms_pkg::ST_JTAG;
          end
        end
        default: state <= fcms_pkg::ST_POWER;
      endcase
    end
  end

  // source latch and load counters
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      src <= fcms_pkg::SRC_NONE;
      modeLatched <= 3'h0;
      addr <= fcms_pkg::PAR_BOTTOM_ADDR;
      byteCnt <= 25'h0;
      xorAcc <= 8'h00;
    end else if (state == fcms_pkg::ST_SAMPLE && settleDone) begin
      src <= modeKind(livePins);
      modeLatched <= livePins;
      byteCnt <= 25'h0;
      xorAcc <= 8'h00;
      if (modeKind(livePins) == fcms_pkg::SRC_PAR_DOWN) begin
        addr <= fcms_pkg::PAR_TOP_ADDR;
      end else begin
        addr <= fcms_pkg::PAR_BOTTOM_ADDR;
      end
    end else if (jtagStart && (state == fcms_pkg::ST_DONE || state == fcms_pkg::ST_FAIL ||
                 state == fcms_pkg::ST_UNSUP)) begin
      byteCnt <= 25'h0;
      xorAcc <= 8'h00;
    end else if (gotByte) begin
      byteCnt <= byteCnt + 25'h1;
      xorAcc <= xorAcc ^ newByte;
      if (state == fcms_pkg::ST_LOAD && src == fcms_pkg::SRC_PAR_DOWN) begin
        addr <= addr - 25'h1;
      end else if (state == fcms_pkg::ST_LOAD && src == fcms_pkg::SRC_PAR_UP) begin
        addr <= addr + 25'h1;
      end
    end
  end

  // config clock divider
  always_ff @(posedge clk_sys) begin
    if (reset || !serialActive || tick) begin
      divCnt <= 8'h00;
    end else begin
      divCnt <= divCnt + 8'h01;
    end
  end

  // serial shifters
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bitCnt <= 5'h0;
      shiftIn <= 8'h00;
      shiftOut <= 32'h0;
    end else if (state == fcms_pkg::ST_SAMPLE) begin
      bitCnt <= 5'h0;
      shiftOut <= fcms_pkg::SPI_READ_CMD;
    end else if (cclkRise) begin
      bitCnt <= bitCnt + 5'h1;
      shiftIn <= {shiftIn[6:0], serialIn};
      if (state == fcms_pkg::ST_CMD) begin
        shiftOut <= {shiftOut[30:0], 1'b0};
      end
    end
  end

  // parallel access timer
  always_ff @(posedge clk_sys) begin
    if (reset || state != fcms_pkg::ST_LOAD || !isPar || gotByte) begin
      accCnt <= 4'h0;
    end else begin
      accCnt <= accCnt + 4'h1;
    end
  end

  // memory pins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flashBus <= '{configClock: 1'b0, promSel_n: 1'b1, spiSel_n: 1'b1,
                    spiMosi: 1'b0, parSel_n: 1'b1, parAddr: 20'h0};
    end else begin
      flashBus.configClock <= serialActive & (flashBus.configClock ^ tick);
      flashBus.promSel_n <= ~(serialActive & (src == fcms_pkg::SRC_PROM));
      flashBus.spiSel_n <= ~(serialActive & (src == fcms_pkg::SRC_SPI));
      flashBus.spiMosi <= (state == fcms_pkg::ST_CMD) & shiftOut[31];
      flashBus.parSel_n <= ~((state == fcms_pkg::ST_LOAD) & isPar);
      flashBus.parAddr <= addr[fcms_pkg::PAR_LOW_BITS-1:0];
    end
  end

  // completion output
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      configDone <= 1'b0;
    end else begin
      configDone <= (state == fcms_pkg::ST_DONE) & ~restart & ~jtagStart;
    end
  end

  // interrupt events
  always_comb begin
    intEvent = 3'h0;
    intEvent[fcms_pkg::INT_DONE_BIT] = finish & imageOk;
    intEvent[fcms_pkg::INT_FAIL_BIT] = finish & ~imageOk;
    intEvent[fcms_pkg::INT_UNSUP_BIT] = (state == fcms_pkg::ST_SAMPLE) & settleDone &
      ~restart & (modeKind(livePins) == fcms_pkg::SRC_NONE);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      intStatus <= 3'h0;
    end else if (wrEn && paddr == fcms_pkg::REG_INT_STATUS) begin
      intStatus <= (intStatus & ~pwdata[fcms_pkg::INT_WIDTH-1:0]) | intEvent;
    end else begin
      intStatus <= intStatus | intEvent;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStatus & intMask);
    end
  end

  // apb handshake, one wait state
  assign access = psel & penable & ~pready;
  assign wrEn = psel & penable & pready & pwrite;
  assign mapped = (paddr == fcms_pkg::REG_CTRL) | (paddr == fcms_pkg::REG_STATUS) |
    (paddr == fcms_pkg::REG_IMAGE_LEN) | (paddr == fcms_pkg::REG_ADDR) |
    (paddr == fcms_pkg::REG_BYTE_CNT) | (paddr == fcms_pkg::REG_INT_STATUS) |
    (paddr == fcms_pkg::REG_INT_MASK);

  always_comb begin
    rdData = 32'h0;
    case (paddr)
      fcms_pkg::REG_STATUS: begin
        rdData[fcms_pkg::STAT_STATE_POS +: 3] = state;
        rdData[fcms_pkg::STAT_SRC_POS +: 3] = src;
        rdData[fcms_pkg::STAT_MODE_POS +: 3] = modeLatched;
        rdData[fcms_pkg::STAT_LIVE_POS +: 3] = modeKind(livePins);
        rdData[fcms_pkg::STAT_DONE_BIT] = configDone;
      end
      fcms_pkg::REG_IMAGE_LEN: rdData = {7'h0, imageLen};
      fcms_pkg::REG_ADDR: rdData = {7'h0, addr};
      fcms_pkg::REG_BYTE_CNT: rdData = {7'h0, byteCnt};
      fcms_pkg::REG_INT_STATUS: rdData = {29'h0, intStatus};
      fcms_pkg::REG_INT_MASK: rdData = {29'h0, intMask};
      default: rdData = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      pslverr <= access & ~mapped;
      if (access && !pwrite) begin
        prdata <= rdData;
      end
    end
  end

  // writable registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      imageLen <= IMAGE_BYTES;
      intMask <= fcms_pkg::INT_MASK_RST;
      softReq <= 1'b0;
    end else begin
      softReq <= wrEn & (paddr == fcms_pkg::REG_CTRL) & pwdata[fcms_pkg::CTRL_RECONFIG_BIT];
      if (wrEn && paddr == fcms_pkg::REG_IMAGE_LEN) begin
        imageLen <= pwdata[24:0];
      end
      if (wrEn && paddr == fcms_pkg::REG_INT_MASK) begin
        intMask <= pwdata[fcms_pkg::INT_WIDTH-1:0];
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/fcms_properties.sv
`default_nettype none
module fcms_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // pins and status
  input wire logic [2:0] modeSelectPins,
  input wire logic reconfigRequest_n,
  input wire fcms_pkg::fcms_flash_t flashBus,
  input wire logic configDone
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] lastPins;
  logic [3:0] pinAge;
  logic idleSel;
  assign idleSel = flashBus.promSel_n & flashBus.spiSel_n & flashBus.parSel_n;
  // age of the current pin code
  always_ff @(posedge clk_sys) begin
    lastPins <= modeSelectPins;
    if (reset || modeSelectPins != lastPins) begin
      pinAge <= 4'h0;
    end else if (pinAge != 4'hf) begin
      pinAge <= pinAge + 4'h1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  done_idle_sel_a: assert property (configDone |-> idleSel)
    else $error("select active while configured");
  prom_code_a: assert property (pinAge > 4'hc && !flashBus.promSel_n
    |-> modeSelectPins == 3'h0)
    else $error("prom selected for other code");
  spi_code_a: assert property (pinAge > 4'hc && !flashBus.spiSel_n
    |-> modeSelectPins == 3'h6)
    else $error("spi selected for other code");
  par_code_a: assert property (pinAge > 4'hc && !flashBus.parSel_n
    |-> modeSelectPins[2:1] == 2'h1)
    else $error("parallel selected for other code");
  unsup_idle_a: assert property (pinAge == 4'hf &&
    !(modeSelectPins inside {3'h0, 3'h2, 3'h3, 3'h6}) |-> idleSel)
    else $error("flash selected for unlisted code");
  par_start_a: assert property ($fell(flashBus.parSel_n) |->
    ##[0:3] flashBus.parAddr == (modeSelectPins[0] ? 20'hfffff : 20'h0))
    else $error("parallel start address wrong");
  button_clear_a: assert property (!reconfigRequest_n [*8] |-> !configDone)
    else $error("done kept during restart");
  apb_answer_a: assert property (psel && !penable ##1 psel && penable |-> ##1 pready)
    else $error("apb answer late");
  err_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error without ready");
  cover property (configDone);
  cover property (!flashBus.parSel_n);
  cover property (pslverr);
endmodule
bind fcms_loader fcms_properties props (.clk_sys(clk_sys), .reset(reset), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .modeSelectPins(modeSelectPins),
  .reconfigRequest_n(reconfigRequest_n), .flashBus(flashBus), .configDone(configDone));
`default_nettype wire

//--- tb/fcms_flash_model.sv
`default_nettype none
module fcms_flash_model (
  // clock
  input wire logic clk_sys,
  // memory side of the loader
  input wire fcms_pkg::fcms_flash_t flashBus,
  input wire logic corrupt,
  output logic serialIn,
  output logic [7:0] parData,
  output logic [31:0] spiCmd
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PATTERN = 8'ha5;
  logic tog = 1'b0;
  logic lastClk = 1'b0;
  logic [15:0] edges = 16'h0;
  logic [15:0] idx;
  always_ff @(posedge clk_sys) begin
    tog <= ~tog;
  end
  // data moves on the falling clock
  always_ff @(posedge clk_sys) begin
    lastClk <= flashBus.configClock;
    if (flashBus.promSel_n && flashBus.spiSel_n) begin
      edges <= 16'h0;
    end else if (lastClk && !flashBus.configClock) begin
      edges <= edges + 16'h1;
    end else if (!lastClk && flashBus.configClock && !flashBus.spiSel_n &&
                 edges < 16'h20) begin
      spiCmd <= {spiCmd[30:0], flashBus.spiMosi};
    end
  end
  assign idx = flashBus.spiSel_n ? edges : edges - 16'h20;
  assign serialIn = (flashBus.promSel_n && flashBus.spiSel_n) || idx[15] ? tog
    : PATTERN[3'h7 - idx[2:0]];
  // byte follows low address, helper owns the upper bits
  assign parData = flashBus.parSel_n ? {8{tog}}
    : flashBus.parAddr[7:0] ^ {7'h0, corrupt && flashBus.parAddr[1:0] == 2'h0};
endmodule
`default_nettype wire

//--- tb/test_fcms_loader.sv
`default_nettype none
module test_fcms_loader;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] modeSelectPins = 3'h0;
  logic reconfigRequest_n = 1'b1;
  logic jtagStart = 1'b0;
  logic jtagValid = 1'b0;
  logic jtagLast = 1'b0;
  logic [7:0] jtagByte = 8'h0;
  logic corrupt = 1'b0;
  logic pready, pslverr, serialIn, configDone, irq, err;
  logic [31:0] prdata, spiCmd, rd;
  logic [7:0] parData;
  fcms_pkg::fcms_flash_t flashBus;
  int fail_count = 0;
  int n_tests = 0;
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  fcms_loader #(.CONFIG_CLOCK_HALF(2), .IMAGE_BYTES(25'h8)) DUT (.clk_sys(clk_sys), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .modeSelectPins(modeSelectPins),
    .reconfigRequest_n(reconfigRequest_n), .serialIn(serialIn), .parData(parData),
    .flashBus(flashBus), .jtagStart(jtagStart), .jtagValid(jtagValid), .jtagByte(jtagByte),
    .jtagLast(jtagLast), .configDone(configDone), .irq(irq));
  fcms_flash_model partner (.clk_sys(clk_sys), .flashBus(flashBus), .corrupt(corrupt),
    .serialIn(serialIn), .parData(parData), .spiCmd(spiCmd));
  task automatic complete_run;
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      fail_count++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic expect_reg(input string name, input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(name, rd, exp);
  endtask
  task automatic wait_state(input logic [2:0] st);
    int i;
    i = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0);
      i++;
    end while (rd[2:0] !== st && i < 3000);
    if (i >= 3000) begin
      fail_count++;
      complete_run();
    end
  endtask
  task automatic restart(input logic [2:0] code, input logic button);
    modeSelectPins <= code;
    repeat (4) @(posedge clk_sys);
    if (button) begin
      reconfigRequest_n <= 1'b0;
      repeat (12) @(posedge clk_sys);
      check("done held", {31'h0, configDone}, 32'h0);
      reconfigRequest_n <= 1'b1;
    end else begin
      apb(1'b1, 8'h00, 32'h1);
    end
  endtask
  // host streams the image over the scan chain
  task automatic jtag_load(input logic [31:0] img);
    @(posedge clk_sys);
    jtagStart <= 1'b1;
    @(posedge clk_sys);
    jtagStart <= 1'b0;
    for (int k = 3; k >= 0; k--) begin
      jtagValid <= 1'b1;
      jtagByte <= img[k*8 +: 8];
      jtagLast <= (k == 0);
      @(posedge clk_sys);
    end
    jtagValid <= 1'b0;
    jtagLast <= 1'b0;
  endtask
  logic [2:0] codes[3] = '{3'h6, 3'h2, 3'h3};
  logic [31:0] stats[3] = '{32'h00012625, 32'h00013235, 32'h00014345};
  logic [2:0] bad[4] = '{3'h1, 3'h4, 3'h5, 3'h7};
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    wait_state(3'h5);
    expect_reg("status prom", 8'h04, 32'h00011015);
    check("done", {31'h0, configDone}, 32'h1);
    expect_reg("prom bytes", 8'h10, 32'h8);
    expect_reg("image len rst", 8'h08, 32'h8);
    apb(1'b1, 8'h08, 32'h4);
    expect_reg("image len", 8'h08, 32'h4);
    expect_reg("int status", 8'h14, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, 8'h18, 32'h7);
    repeat (3) @(posedge clk_sys);
    check("irq open", {31'h0, irq}, 32'h1);
    apb(1'b1, 8'h14, 32'h1);
    repeat (3) @(posedge clk_sys);
    check("irq cleared", {31'h0, irq}, 32'h0);
    for (int i = 0; i < 3; i++) begin
      restart(codes[i], i == 1);
      wait_state(3'h5);
      expect_reg("status mode", 8'h04, stats[i]);
    end
    check("spi command", spiCmd, 32'h03000000);
    expect_reg("down addr", 8'h0c, 32'h01fffffb);
    expect_reg("down bytes", 8'h10, 32'h4);
    corrupt <= 1'b1;
    restart(3'h3, 1'b0);
    wait_state(3'h6);
    check("done on fail", {31'h0, configDone}, 32'h0);
    expect_reg("int fail", 8'h14, 32'h3);
    apb(1'b1, 8'h14, 32'h7);
    corrupt <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      restart(bad[i], 1'b0);
      wait_state(3'h7);
      expect_reg("status unsup", 8'h04, {21'h0, bad[i], 8'h07});
    end
    expect_reg("int unsup", 8'h14, 32'h4);
    apb(1'b1, 8'h14, 32'h7);
    jtag_load(32'h12345670);
    wait_state(3'h5);
    check("done jtag", {31'h0, configDone}, 32'h1);
    expect_reg("int jtag", 8'h14, 32'h1);
    expect_reg("unmapped", 8'h40, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    complete_run();
  end
endmodule
`default_nettype wire
